// ---- rtl/pdc_defs.svh ----
/*
  Constants for the paged memory card bus logic: control port fields,
  reset values, page field position and synchroniser depth.
  Assumes inclusion by bare name from design files only.
*/
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

`define PDC_CTL_PAR_BIT 7
`define PDC_CTL_EN_BIT 6
`define PDC_CTL_RESET 8'h00
`define PDC_EN_RESET 1'b0
`define PDC_PORT_FACTORY 8'h70
`define PDC_HI_ADDR_W 4
`define PDC_PAGE_MSB 3
`define PDC_PAGE_LSB 2
`define PDC_SYNC_STAGES 3

`endif

// ---- rtl/pdc_pkg.sv ----
/*
  Types for the paged memory card bus logic.
  Assumes the constants header is compiled alongside.
*/
package pdc_pkg;

  typedef enum logic [3:0] {
    PDC_IDLE  = 4'b0001,
    PDC_WAIT  = 4'b0010,
    PDC_DRIVE = 4'b0100,
    PDC_DONE  = 4'b1000
  } pdc_mem_state_t;

endpackage

// ---- rtl/pdc_sync.sv ----
/*
  Three-stage input synchroniser bank with agreement filter.
  Assumes inputs are asynchronous to clk_i; the output follows only when
  the second and third stages agree.
*/
`timescale 1ns/100ps
`include "pdc_defs.svh"

module pdc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pdc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_agree
      assign agree[g] = (stage2_reg[g] == stage3_reg[g]);
    end
  endgenerate

  // One process owns the output; a bit holds while its last two stages disagree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_o <= RESET_VAL;
    else
      sync_o <= (stage3_reg & agree) | (sync_o & ~agree);
  end

endmodule

// ---- rtl/pdc_card.sv ----
/*
  Bus-side control of a paged dynamic RAM card: high address capture,
  page decode, control/status port, odd parity and priority chain.
  Assumes an external DRAM sequencer that answers each request with a
  one-cycle ack and does its own row/column timing; bus pins arrive
  asynchronously and the system reset drives rst_n_i.
*/
`timescale 1ns/100ps
`include "pdc_defs.svh"

module pdc_card #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic ale_n_i,
  input wire logic memrq_n_i,
  input wire logic iorq_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic refresh_n_i,
  input wire logic busak_n_i,
  output logic chain_n_o,
  output logic chain_oe_o,
  input wire logic [7:0] port_number_jumpers_i,
  input wire logic [1:0] page_select_jumpers_i,
  input wire logic priority_chain_jumper_i,
  output logic dram_req_o,
  output logic dram_we_o,
  output logic [ADDR_W+1:0] dram_addr_o,
  output logic [DATA_W:0] dram_wdata_o,
  input wire logic [DATA_W:0] dram_rdata_i,
  input wire logic dram_ack_i,
  output logic dram_refresh_o,
  output logic card_enable_o,
  output logic parity_error_flag_o
);

  // Strobes, chain jumper, page jumpers, port jumpers, address, data
  localparam int SYNC_W = 7 + 1 + 2 + 8 + ADDR_W + DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_RST = {7'h7F, {(SYNC_W-7){1'b0}}};

  if (ADDR_W != 16 || DATA_W != 8)
  begin : g_bad_bus
    $error("pdc_card: bus must be 16 address and 8 data bits");
  end

  logic [SYNC_W-1:0] sync_vec;
  logic ale_n_s, memrq_n_s, iorq_n_s, rd_n_s, wr_n_s, refresh_n_s, busak_n_s;
  logic chain_jmp_s;
  logic [1:0] page_s;
  logic [7:0] port_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  // Address and data settle well before the strobes, so per-bit skew is harmless
  pdc_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RST)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({ale_n_i, memrq_n_i, iorq_n_i, rd_n_i, wr_n_i, refresh_n_i, busak_n_i,
      priority_chain_jumper_i, page_select_jumpers_i, port_number_jumpers_i, addr_i, data_i}),
    .sync_o(sync_vec)
  );

  assign {ale_n_s, memrq_n_s, iorq_n_s, rd_n_s, wr_n_s, refresh_n_s, busak_n_s,
    chain_jmp_s, page_s, port_s, addr_s, data_s} = sync_vec;

  function automatic logic odd_fill(input logic [DATA_W-1:0] d);
    odd_fill = ~(^d);
  endfunction

  function automatic logic port_hit(input logic [ADDR_W-1:0] a, input logic [7:0] jp);
    port_hit = (a[7:0] == jp);
  endfunction

  logic rd_prev_reg, wr_prev_reg, rf_prev_reg;
  logic [`PDC_HI_ADDR_W-1:0] hi_addr_reg;
  logic par_reg;
  pdc_pkg::pdc_mem_state_t state_reg;

  wire rd_start = rd_prev_reg & ~rd_n_s;
  wire wr_start = wr_prev_reg & ~wr_n_s;
  wire mem_start = ~memrq_n_s & (rd_start | wr_start);
  wire page_hit = (hi_addr_reg[`PDC_PAGE_MSB:`PDC_PAGE_LSB] == page_s);
  wire io_rd_start = ~iorq_n_s & rd_start & port_hit(addr_s, port_s);
  wire io_wr_start = ~iorq_n_s & wr_start & port_hit(addr_s, port_s);
  wire refresh_start = rf_prev_reg & ~refresh_n_s & ~memrq_n_s;
  wire rd_ack = (state_reg == pdc_pkg::PDC_WAIT) & dram_ack_i & ~dram_we_o;
  wire rd_bad = rd_ack & ~(^dram_rdata_i);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      rf_prev_reg <= 1'b1;
    end
    else
    begin
      rd_prev_reg <= rd_n_s;
      wr_prev_reg <= wr_n_s;
      rf_prev_reg <= refresh_n_s;
    end
  end

  // Transparent while strobe low, holds after it rises
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hi_addr_reg <= '0;
    else if (!ale_n_s)
      hi_addr_reg <= data_s[`PDC_HI_ADDR_W-1:0];
  end

  // Card enable, cleared by reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      card_enable_o <= `PDC_EN_RESET;
    else if (io_wr_start)
      card_enable_o <= data_s[`PDC_CTL_EN_BIT];
  end

  // A new error in the clearing cycle wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      par_reg <= 1'b0;
    else if (rd_bad)
      par_reg <= 1'b1;
    else if (io_wr_start)
      par_reg <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      parity_error_flag_o <= 1'b0;
    else
      parity_error_flag_o <= par_reg | rd_bad;
  end

  // Memory cycle sequencing
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= pdc_pkg::PDC_IDLE;
      dram_req_o <= 1'b0;
      dram_we_o <= 1'b0;
      dram_addr_o <= '0;
      dram_wdata_o <= '0;
    end
    else
    begin
      dram_req_o <= 1'b0;
      case (state_reg)
        pdc_pkg::PDC_IDLE:
        begin
          if (mem_start && page_hit && card_enable_o)
          begin
            dram_req_o <= 1'b1;
            dram_we_o <= wr_start;
            dram_addr_o <= {hi_addr_reg[1:0], addr_s};
            dram_wdata_o <= {odd_fill(data_s), data_s};
            state_reg <= pdc_pkg::PDC_WAIT;
          end
        end
        pdc_pkg::PDC_WAIT:
        begin
          if (dram_ack_i)
            state_reg <= pdc_pkg::PDC_DRIVE;
        end
        pdc_pkg::PDC_DRIVE:
        begin
          if (rd_n_s && wr_n_s)
            state_reg <= pdc_pkg::PDC_DONE;
        end
        pdc_pkg::PDC_DONE:
          state_reg <= pdc_pkg::PDC_IDLE;
        default:
          state_reg <= pdc_pkg::PDC_IDLE;
      endcase
    end
  end

  // Refresh is passed on whatever the enable says
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dram_refresh_o <= 1'b0;
    else
      dram_refresh_o <= refresh_start;
  end

  // Bus drive: memory data or control status, dropped when read ends
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end
    else if (rd_ack)
    begin
      data_o <= dram_rdata_i[DATA_W-1:0];
      data_oe_o <= 1'b1;
    end
    else if (io_rd_start)
    begin
      data_o <= {par_reg, card_enable_o, 6'h00};
      data_oe_o <= 1'b1;
    end
    else if (rd_n_s)
      data_oe_o <= 1'b0;
  end

  // Chain is only driven when the jumper is fitted
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chain_n_o <= 1'b1;
      chain_oe_o <= 1'b0;
    end
    else
    begin
      chain_n_o <= busak_n_s;
      chain_oe_o <= chain_jmp_s;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence io_write_s;
    io_wr_start ##1 1'b1;
  endsequence

  hi_nibble_latch_a: assert property (!ale_n_s |=> hi_addr_reg == $past(data_s[3:0]))
    else $error("high address nibble not captured");
  page_req_addr_a: assert property ((state_reg == pdc_pkg::PDC_IDLE && mem_start && page_hit && card_enable_o)
    |=> dram_req_o && dram_addr_o == {$past(hi_addr_reg[1:0]), $past(addr_s)})
    else $error("page hit did not issue request with full address");
  page_miss_idle_a: assert property ((state_reg == pdc_pkg::PDC_IDLE && !page_hit) |=> !dram_req_o)
    else $error("request issued outside selected page");
  disabled_quiet_a: assert property ((state_reg == pdc_pkg::PDC_IDLE && !card_enable_o) |=> !dram_req_o)
    else $error("disabled card started a memory cycle");
  enable_write_a: assert property (io_write_s |-> card_enable_o == $past(data_s[6]))
    else $error("card enable not taken from bit 6");
  write_parity_a: assert property ((dram_req_o && dram_we_o) |-> ^dram_wdata_o)
    else $error("stored parity not odd");
  parity_set_a: assert property (rd_bad |=> par_reg ##1 parity_error_flag_o)
    else $error("parity error not flagged");
  parity_sticky_a: assert property ((par_reg && !io_wr_start) |=> par_reg)
    else $error("parity flag dropped without port write");
  status_read_a: assert property ((io_rd_start && !rd_ack) |=> data_oe_o && data_o[7] == $past(par_reg)
    && data_o[5:0] == 6'h00)
    else $error("status read wrong");
  refresh_pass_a: assert property (refresh_start |=> dram_refresh_o)
    else $error("refresh not passed on");
  chain_pass_a: assert property (1'b1 |=> chain_oe_o == $past(chain_jmp_s) && chain_n_o == $past(busak_n_s))
    else $error("chain not passed through");

endmodule

// ---- tb/pdc_dram_model.sv ----
/*
  Stand-in for the DRAM sequencer: one-cycle ack three clocks after req.
  Assumes address, data and we stand from req until the next req.
*/
`timescale 1ns/100ps
module pdc_dram_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [17:0] addr_i,
  input wire logic [8:0] wdata_i,
  input wire logic flip_i,
  output logic [8:0] rdata_o,
  output logic ack_o
);
  logic [8:0] mem [0:262143];
  logic [1:0] dly;
  // Unwritten cells read as even ones, as real parity would be random
  initial
  begin
    for (int i = 0; i < 262144; i++)
      mem[i] = 9'h000;
  end
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dly <= 2'h0;
      ack_o <= 1'b0;
      rdata_o <= 9'h000;
    end
    else
    begin
      dly <= {dly[0], req_i};
      ack_o <= dly[1];
      // Read data toggles outside ack so a stale value never passes
      rdata_o <= ~rdata_o;
      if (dly[1] && we_i)
        mem[addr_i] <= wdata_i;
      if (dly[1] && !we_i)
        rdata_o <= mem[addr_i] ^ {flip_i, 8'h00};
    end
  end
endmodule

// ---- tb/paged_dram_card_bus_interface_bench.sv ----
/*
  Self-checking bench for the paged memory card; the bench acts as bus master.
  Assumes the DRAM model answers every request.
*/
`timescale 1ns/100ps
module paged_dram_card_bus_interface_bench;
  logic clk_i = 1'b0, rst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] data_i = 8'h00, data_o, q, port_j = 8'h70;
  logic [1:0] page_j = 2'h1;
  logic last_we;
  logic data_oe_o, ale_n_i = 1'b1, memrq_n_i = 1'b1, iorq_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1;
  logic refresh_n_i = 1'b1, busak_n_i = 1'b1, chain_n_o, chain_oe_o, chain_j = 1'b0, flip = 1'b0;
  logic dram_req_o, dram_we_o, dram_ack_i, dram_refresh_o, card_enable_o, parity_error_flag_o;
  logic [17:0] dram_addr_o, last_addr;
  logic [8:0] dram_wdata_o, dram_rdata_i, last_wdata;
  int error_cnt = 0, checks_done = 0, reqs = 0, refs = 0, ticks = 0;
  initial forever #5 clk_i = ~clk_i;
  pdc_card dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .ale_n_i(ale_n_i), .memrq_n_i(memrq_n_i), .iorq_n_i(iorq_n_i), .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i), .refresh_n_i(refresh_n_i), .busak_n_i(busak_n_i), .chain_n_o(chain_n_o),
    .chain_oe_o(chain_oe_o), .port_number_jumpers_i(port_j), .page_select_jumpers_i(page_j),
    .priority_chain_jumper_i(chain_j), .dram_req_o(dram_req_o), .dram_we_o(dram_we_o),
    .dram_addr_o(dram_addr_o), .dram_wdata_o(dram_wdata_o), .dram_rdata_i(dram_rdata_i),
    .dram_ack_i(dram_ack_i), .dram_refresh_o(dram_refresh_o), .card_enable_o(card_enable_o),
    .parity_error_flag_o(parity_error_flag_o));
  pdc_dram_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(dram_req_o), .we_i(dram_we_o),
    .addr_i(dram_addr_o), .wdata_i(dram_wdata_o), .flip_i(flip), .rdata_o(dram_rdata_i), .ack_o(dram_ack_i));
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (dram_req_o === 1'b1)
    begin
      reqs <= reqs + 1;
      last_addr <= dram_addr_o;
      last_wdata <= dram_wdata_o;
      last_we <= dram_we_o;
    end
    if (dram_refresh_o === 1'b1)
      refs <= refs + 1;
    // Ceiling well above the roughly 500 cycles the tests need
    if (ticks == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Port access; strobes stand 12 clocks to clear the synchroniser
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    addr_i = a;
    data_i = d;
    iorq_n_i = 1'b0;
    if (w)
      wr_n_i = 1'b0;
    else
      rd_n_i = 1'b0;
    cyc(12);
    q = data_oe_o ? data_o : 8'hEE;
    iorq_n_i = 1'b1;
    rd_n_i = 1'b1;
    wr_n_i = 1'b1;
    cyc(8);
  endtask
  // Memory access: high nibble on data during ale, then the strobes
  task automatic mem(input logic [3:0] hi, input logic [15:0] a, input logic w, input logic [7:0] d);
    ale_n_i = 1'b0;
    addr_i = a;
    data_i = {4'h0, hi};
    cyc(4);
    ale_n_i = 1'b1;
    data_i = w ? d : 8'h5A;
    memrq_n_i = 1'b0;
    if (w)
      wr_n_i = 1'b0;
    else
      rd_n_i = 1'b0;
    cyc(16);
    q = data_oe_o ? data_o : 8'hEE;
    memrq_n_i = 1'b1;
    rd_n_i = 1'b1;
    wr_n_i = 1'b1;
    cyc(8);
  endtask
  task automatic t_enable;
    chk(card_enable_o, 1'b0);
    io(16'hAB70, 1'b1, 8'h40);
    chk(card_enable_o, 1'b1);
    io(16'h0071, 1'b1, 8'h00);
    chk(card_enable_o, 1'b1);
    io(16'h1270, 1'b0, 8'h00);
    chk(q, 8'h40);
    $display("test enable done");
  endtask
  task automatic t_memory;
    int n;
    n = reqs;
    mem(4'h5, 16'h1234, 1'b1, 8'h3C);
    chk(last_addr, 18'h11234);
    chk(last_wdata, {~^8'h3C, 8'h3C});
    mem(4'h7, 16'hFFFF, 1'b1, 8'h01);
    chk(last_wdata, {~^8'h01, 8'h01});
    mem(4'h5, 16'h1234, 1'b0, 8'h00);
    chk(q, 8'h3C);
    chk(parity_error_flag_o, 1'b0);
    mem(4'h9, 16'h1234, 1'b0, 8'h00);
    chk(reqs, n + 3);
    chk(q, 8'hEE);
    $display("test memory done");
  endtask
  task automatic t_parity;
    flip = 1'b1;
    mem(4'h5, 16'h1234, 1'b0, 8'h00);
    flip = 1'b0;
    chk(parity_error_flag_o, 1'b1);
    mem(4'h7, 16'hFFFF, 1'b0, 8'h00);
    chk(q, 8'h01);
    io(16'h0070, 1'b0, 8'h00);
    chk(q, 8'hC0);
    io(16'h0070, 1'b1, 8'h40);
    chk(parity_error_flag_o, 1'b0);
    $display("test parity done");
  endtask
  task automatic t_disabled;
    int n, r;
    io(16'h0070, 1'b1, 8'h00);
    chk(card_enable_o, 1'b0);
    n = reqs;
    r = refs;
    mem(4'h5, 16'h1234, 1'b0, 8'h00);
    chk(reqs, n);
    chk(q, 8'hEE);
    memrq_n_i = 1'b0;
    refresh_n_i = 1'b0;
    cyc(8);
    memrq_n_i = 1'b1;
    refresh_n_i = 1'b1;
    cyc(8);
    chk(refs, r + 1);
    $display("test disabled done");
  endtask
  // Other jumper settings; card starts this test disabled
  task automatic t_jumpers;
    int n;
    port_j = 8'h3C;
    page_j = 2'h3;
    cyc(8);
    io(16'h0070, 1'b1, 8'h40);
    chk(card_enable_o, 1'b0);
    io(16'h553C, 1'b1, 8'h40);
    chk(card_enable_o, 1'b1);
    n = reqs;
    mem(4'h5, 16'h0042, 1'b1, 8'h7E);
    chk(reqs, n);
    mem(4'hD, 16'h0042, 1'b1, 8'h7E);
    chk(last_addr, 18'h10042);
    chk(last_we, 1'b1);
    mem(4'hD, 16'h0042, 1'b0, 8'h00);
    chk(q, 8'h7E);
    chk(last_we, 1'b0);
    port_j = 8'h70;
    page_j = 2'h1;
    cyc(8);
    $display("test jumpers done");
  endtask
  task automatic t_chain;
    chk(chain_oe_o, 1'b0);
    chain_j = 1'b1;
    busak_n_i = 1'b0;
    cyc(8);
    chk({chain_oe_o, chain_n_o}, 2'h2);
    busak_n_i = 1'b1;
    cyc(8);
    chk(chain_n_o, 1'b1);
    $display("test chain done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    cyc(2);
    rst_n_i = 1'b1;
    cyc(2);
    t_enable();
    t_memory();
    t_parity();
    t_disabled();
    t_jumpers();
    t_chain();
    results();
  end
endmodule
